// ==== logic/btw_consts.svh ====
// Constants of the bounds-table walker.
`ifndef BTW_CONSTS_SVH
`define BTW_CONSTS_SVH
`define BTW_CPL_USER 2'h3
`define BTW_DIR_BASE_LSB 12
`define BTW_DE_VALID_BIT 0
`define BTW_EC_NONE 2'h0
`define BTW_EC_BOUNDS 2'h1
`define BTW_EC_BAD_DE 2'h2
`define BTW_EC_RSVD 2'h3
`define BTW_CFG_RESET 64'h0000_0000_0000_0000
`define BTW_STS_RESET 64'h0000_0000_0000_0000
`define BTW_OFS_CFG_USER 4'h0
`define BTW_OFS_CFG_SUPV 4'h1
`define BTW_OFS_STATUS 4'h2
`define BTW_OFS_WADJ 4'h3
`define BTW_OFS_SEG_DATA 4'h4
`define BTW_WADJ_LSB 17
`define BTW_WADJ_MSB 21
`define BTW_FIELDS 3'h4
`endif

// ==== logic/btw_pkg.sv ====
// Types of the bounds-table walker.
`default_nettype none
package btw_pkg;
  typedef enum logic [2:0] {
    BTW_IDLE = 3'h0,
    BTW_DE_REQ = 3'h1,
    BTW_DE_WAIT = 3'h3,
    BTW_TE_REQ = 3'h2,
    BTW_TE_WAIT = 3'h6,
    BTW_DONE = 3'h4
  } btw_state_t;
endpackage : btw_pkg
`default_nettype wire

// ==== logic/btw_walker.sv ====
// Bounds-table walker: directory and table lookup for indexed bounds load and store.
// ==================================================
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "btw_consts.svh"
module btw_walker (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_init,
  input wire logic [3:0] i_reg_addr,
  input wire logic [63:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [63:0] o_reg_rdata,
  input wire logic i_op_start,
  input wire logic i_op_store,
  input wire logic i_mode64,
  input wire logic i_mode16,
  input wire logic i_addr_prefix,
  input wire logic [1:0] i_privilege_level,
  input wire logic [63:0] i_seg_base,
  input wire logic [63:0] i_pointer_storage_addr,
  input wire logic [63:0] i_lower_bound,
  input wire logic [63:0] i_upper_bound,
  input wire logic [63:0] i_pointer_value,
  output logic o_busy,
  output logic o_done,
  output logic o_bound_range_fault,
  output logic o_undefined_opcode_fault,
  output logic [63:0] o_lower_bound,
  output logic [63:0] o_upper_bound,
  output logic [63:0] o_pointer_value,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic o_mem_wide,
  output logic [63:0] o_mem_addr,
  output logic [63:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [63:0] i_mem_rdata
);
  // ==================================================
  // State
  typedef struct packed {
    btw_pkg::btw_state_t st;
    logic [63:0] cfg_user;
    logic [63:0] cfg_supv;
    logic [63:0] status;
    logic [4:0] wadj_user;
    logic [63:0] seg_data;
    logic [63:0] rdata;
    logic store;
    logic wide;
    logic [63:0] lin;
    logic [63:0] dir_base;
    logic [4:0] wadj;
    logic [63:0] tbl_base;
    logic [2:0] fld;
    logic [63:0] lb;
    logic [63:0] ub;
    logic [63:0] pv;
    logic done;
    logic brf;
    logic udf;
    logic req;
    logic we;
    logic [63:0] addr;
    logic [63:0] wdata;
  } btw_state_s_t;

  btw_state_s_t s_r;
  btw_state_s_t s_nxt;

  // Narrow values are zero-extended so upper halves stay clear.
  function automatic logic [63:0] btw_fit(input logic wide, input logic [63:0] v);
    btw_fit = wide ? v : {32'h0000_0000, v[31:0]};
  endfunction : btw_fit

  // Directory offset for the wide and narrow layouts.
  function automatic logic [63:0] btw_dir_ofs(input logic wide, input logic [4:0] adj,
                                              input logic [63:0] la);
    logic [63:0] m;
    m = (64'h0000_0000_1000_0000 << adj) - 64'h0000_0000_0000_0001;
    if (wide) begin
      btw_dir_ofs = ((la >> 20) & m) << 3;
    end else begin
      btw_dir_ofs = {42'h0, la[31:12], 2'h0};
    end
  endfunction : btw_dir_ofs

  logic [63:0] sel_cfg;
  logic [63:0] te_ofs;
  logic [63:0] ld_val;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.brf = 1'b0;
    s_nxt.udf = 1'b0;
    s_nxt.rdata = 64'h0000_0000_0000_0000;
    sel_cfg = (i_privilege_level == `BTW_CPL_USER) ? s_r.cfg_user : s_r.cfg_supv;
    te_ofs = s_r.wide ? {42'h0, s_r.lin[19:3], 5'h00}
                      : {50'h0, s_r.lin[11:2], 4'h0};
    ld_val = btw_fit(s_r.wide, i_mem_rdata);
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `BTW_OFS_CFG_USER: s_nxt.rdata = s_r.cfg_user;
        `BTW_OFS_CFG_SUPV: s_nxt.rdata = s_r.cfg_supv;
        `BTW_OFS_STATUS: s_nxt.rdata = s_r.status;
        `BTW_OFS_WADJ: s_nxt.rdata = {42'h0, s_r.wadj_user, 17'h0_0000};
        `BTW_OFS_SEG_DATA: s_nxt.rdata = s_r.seg_data;
        default: s_nxt.rdata = 64'h0000_0000_0000_0000;
      endcase
    end
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `BTW_OFS_CFG_USER: s_nxt.cfg_user = i_reg_wdata;
        `BTW_OFS_CFG_SUPV: s_nxt.cfg_supv = i_reg_wdata;
        `BTW_OFS_STATUS: s_nxt.status = i_reg_wdata;
        `BTW_OFS_WADJ: s_nxt.wadj_user = i_reg_wdata[`BTW_WADJ_MSB:`BTW_WADJ_LSB];
        `BTW_OFS_SEG_DATA: s_nxt.seg_data = i_reg_wdata;
        default: s_nxt.seg_data = s_r.seg_data;
      endcase
    end
    unique case (s_r.st)
      btw_pkg::BTW_IDLE: begin
        if (i_op_start) begin
          s_nxt.store = i_op_store;
          if (!i_mode64 && (i_addr_prefix != i_mode16)) begin
            s_nxt.udf = 1'b1;
            s_nxt.done = 1'b1;
          end else begin
            // Prefix has no effect in wide mode.
            s_nxt.wide = i_mode64;
            s_nxt.lin = btw_fit(i_mode64, i_seg_base + i_pointer_storage_addr);
            s_nxt.wadj = (i_privilege_level == `BTW_CPL_USER) ? s_r.wadj_user : 5'h00;
            s_nxt.dir_base = i_mode64 ? {sel_cfg[63:`BTW_DIR_BASE_LSB], 12'h000}
                                      : {32'h0, sel_cfg[31:`BTW_DIR_BASE_LSB], 12'h000};
            s_nxt.lb = btw_fit(i_mode64, i_lower_bound);
            s_nxt.ub = btw_fit(i_mode64, i_upper_bound);
            s_nxt.pv = btw_fit(i_mode64, i_pointer_value);
            s_nxt.st = btw_pkg::BTW_DE_REQ;
          end
        end
      end
      btw_pkg::BTW_DE_REQ: begin
        s_nxt.addr = btw_fit(s_r.wide, s_r.dir_base
                     + btw_dir_ofs(s_r.wide, s_r.wadj, s_r.lin));
        s_nxt.req = 1'b1;
        s_nxt.we = 1'b0;
        s_nxt.st = btw_pkg::BTW_DE_WAIT;
      end
      btw_pkg::BTW_DE_WAIT: begin
        if (i_mem_ack) begin
          s_nxt.req = 1'b0;
          if (!ld_val[`BTW_DE_VALID_BIT]) begin
            // No table access follows a bad entry.
            s_nxt.status = {s_r.addr[63:2], `BTW_EC_BAD_DE};
            s_nxt.brf = 1'b1;
            s_nxt.done = 1'b1;
            s_nxt.st = btw_pkg::BTW_IDLE;
          end else begin
            s_nxt.tbl_base = s_r.wide ? {ld_val[63:3], 3'h0}
                                      : {32'h0, ld_val[31:2], 2'h0};
            s_nxt.fld = 3'h0;
            s_nxt.st = btw_pkg::BTW_TE_REQ;
          end
        end
      end
      btw_pkg::BTW_TE_REQ: begin
        // Fields in order lower, upper, pointer, reserved.
        s_nxt.addr = s_r.wide ? s_r.tbl_base + te_ofs + {58'h0, s_r.fld, 3'h0}
                              : btw_fit(1'b0, s_r.seg_data + s_r.tbl_base + te_ofs
                                + {59'h0, s_r.fld, 2'h0});
        s_nxt.we = s_r.store;
        s_nxt.wdata = (s_r.fld == 3'h0) ? s_r.lb : (s_r.fld == 3'h1) ? s_r.ub
                    : (s_r.fld == 3'h2) ? s_r.pv : 64'h0000_0000_0000_0000;
        s_nxt.req = 1'b1;
        s_nxt.st = btw_pkg::BTW_TE_WAIT;
      end
      btw_pkg::BTW_TE_WAIT: begin
        if (i_mem_ack) begin
          s_nxt.req = 1'b0;
          if (!s_r.store) begin
            unique case (s_r.fld)
              3'h0: s_nxt.lb = ld_val;
              3'h1: s_nxt.ub = ld_val;
              3'h2: s_nxt.pv = ld_val;
              default: s_nxt.pv = s_r.pv;
            endcase
          end
          s_nxt.fld = s_r.fld + 3'h1;
          // Reserved field is skipped on load, written as zero on store.
          if ((s_r.fld == 3'h3) || (!s_r.store && s_r.fld == 3'h2)) begin
            s_nxt.st = btw_pkg::BTW_DONE;
          end else begin
            s_nxt.st = btw_pkg::BTW_TE_REQ;
          end
        end
      end
      btw_pkg::BTW_DONE: begin
        s_nxt.done = 1'b1;
        s_nxt.st = btw_pkg::BTW_IDLE;
      end
      default: s_nxt.st = btw_pkg::BTW_IDLE;
    endcase
    if (i_init) begin
      s_nxt.cfg_user = `BTW_CFG_RESET;
      s_nxt.cfg_supv = `BTW_CFG_RESET;
      s_nxt.status = `BTW_STS_RESET;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_reg_rdata = s_r.rdata;
  assign o_busy = (s_r.st != btw_pkg::BTW_IDLE);
  assign o_done = s_r.done;
  assign o_bound_range_fault = s_r.brf;
  assign o_undefined_opcode_fault = s_r.udf;
  assign o_lower_bound = s_r.lb;
  assign o_upper_bound = s_r.ub;
  assign o_pointer_value = s_r.pv;
  assign o_mem_req = s_r.req;
  assign o_mem_we = s_r.we;
  assign o_mem_wide = s_r.wide;
  assign o_mem_addr = s_r.addr;
  assign o_mem_wdata = s_r.wdata;

  // ==================================================
  // Assertions
  sequence s_bad_de;
    s_r.st == btw_pkg::BTW_DE_WAIT && i_mem_ack && !i_mem_rdata[0];
  endsequence

  property p_bad_de_code;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_bad_de and !i_init |=> (s_r.status[1:0] == 2'h2) && o_bound_range_fault;
  endproperty
  a_bad_de_code: assert property (p_bad_de_code) else $error("bad entry code wrong");

  property p_bad_de_addr;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_bad_de and !i_init |=> s_r.status[63:2] == $past(o_mem_addr[63:2]);
  endproperty
  a_bad_de_addr: assert property (p_bad_de_addr) else $error("bad entry addr wrong");

  property p_no_te_after_bad;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_bad_de |=> !o_mem_req [*2];
  endproperty
  a_no_te_after_bad: assert property (p_no_te_after_bad) else $error("extra access");

  property p_narrow_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
      !o_mem_wide |-> o_lower_bound[63:32] == 32'h0000_0000;
  endproperty
  a_narrow_clear: assert property (p_narrow_clear) else $error("upper half not clear");

  property p_init_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_init |=> s_r.cfg_user == 64'h0 && s_r.cfg_supv == 64'h0 && s_r.status == 64'h0;
  endproperty
  a_init_clear: assert property (p_init_clear) else $error("init did not clear");

  property p_ud;
    @(posedge i_clk) disable iff (i_sys_rst)
      (!o_busy && i_op_start && !i_mode64 && i_addr_prefix != i_mode16)
      |=> o_undefined_opcode_fault && o_done && !o_busy;
  endproperty
  a_ud: assert property (p_ud) else $error("prefix fault missing");

  property p_de_align;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_r.st == btw_pkg::BTW_DE_WAIT |-> o_mem_addr[1:0] == 2'h0 && o_mem_req;
  endproperty
  a_de_align: assert property (p_de_align) else $error("entry address misaligned");

  property p_store_we;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_r.st == btw_pkg::BTW_TE_WAIT |-> o_mem_we == s_r.store;
  endproperty
  a_store_we: assert property (p_store_we) else $error("table write enable wrong");

  property p_req_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");

  property p_narrow_upper;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_mem_req && !o_mem_wide |-> o_mem_addr[63:32] == 32'h0000_0000
        && (!o_mem_we || o_mem_wdata[63:32] == 32'h0000_0000);
  endproperty
  a_narrow_upper: assert property (p_narrow_upper) else $error("narrow upper half set");

  sequence s_op_taken;
    !o_busy && i_op_start && (i_mode64 || (i_addr_prefix == i_mode16));
  endsequence

  sequence s_de_issued;
    o_mem_req && !o_mem_we && (s_r.st == btw_pkg::BTW_DE_WAIT);
  endsequence

  property p_de_first;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_op_taken |-> ##2 s_de_issued;
  endproperty
  a_de_first: assert property (p_de_first) else $error("directory read not first");

  property p_wide_de_align;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_de_issued and o_mem_wide |-> o_mem_addr[2:0] == 3'h0;
  endproperty
  a_wide_de_align: assert property (p_wide_de_align) else $error("wide entry misaligned");

  property p_load_no_write;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_mem_req && !s_r.store |-> !o_mem_we;
  endproperty
  a_load_no_write: assert property (p_load_no_write) else $error("load wrote memory");
endmodule : btw_walker
`default_nettype wire

// ==== tb/btw_mem_model.sv ====
// Memory system model holding the bound directory and the bound tables.
`timescale 1ns/1ps
`default_nettype none
module btw_mem_model (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_mem_req,
  input wire logic i_mem_we,
  input wire logic i_mem_wide,
  input wire logic [63:0] i_mem_addr,
  input wire logic [63:0] i_mem_wdata,
  output logic o_mem_ack,
  output logic [63:0] o_mem_rdata
);
  // ==========================================================
  // Storage, access count and answer.
  logic [63:0] mem [logic [63:0]];
  int n_acc = 0;
  int wait_r = 0;
  function automatic logic [63:0] fetch(input logic [63:0] a, input logic w);
    logic [63:0] d;
    d = mem.exists(a) ? mem[a] : ~a;
    return w ? d : {~d[31:0], d[31:0]};
  endfunction : fetch
  // Every other access waits three cycles; idle read data toggles each cycle.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mem_ack <= 1'b0;
      o_mem_rdata <= 64'h0;
      wait_r <= 0;
    end else if (!o_mem_ack && i_mem_req && wait_r == (n_acc % 2) * 3) begin
      o_mem_ack <= 1'b1;
      o_mem_rdata <= fetch(i_mem_addr, i_mem_wide);
      wait_r <= 0;
      n_acc <= n_acc + 1;
      if (i_mem_we) begin
        mem[i_mem_addr] = i_mem_wide ? i_mem_wdata : {32'h0, i_mem_wdata[31:0]};
      end
    end else begin
      o_mem_ack <= 1'b0;
      o_mem_rdata <= ~o_mem_rdata;
      if (!o_mem_ack && i_mem_req) begin
        wait_r <= wait_r + 1;
      end
    end
  end
endmodule : btw_mem_model
`default_nettype wire

// ==== tb/btw_walker_test.sv ====
// Testbench of the bounds-table walker.
`timescale 1ns/1ps
`default_nettype none
`define BTW_CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t %s", $time, m); end end
module btw_walker_test;
  // ==========================================================
  // Signals and instances.
  localparam logic [63:0] UCFG = 64'h0000_0001_2340_0003;
  localparam logic [63:0] SCFG = 64'h0000_0002_0000_0001;
  localparam logic [63:0] DSEG = 64'h0000_0000_0010_0000;
  localparam int WADJ = 3;
  logic clk = 1'b0, rst = 1'b1, init = 1'b0, rwr = 1'b0, rrd = 1'b0, start = 1'b0;
  logic store = 1'b0, m64 = 1'b0, m16 = 1'b0, pfx = 1'b0;
  logic [1:0] privilege_level = 2'h0;
  logic [3:0] raddr = 4'h0;
  logic [63:0] wdata = 64'h0, seg = 64'h0, pa = 64'h0, rv;
  logic [63:0] lb = 64'hAAAA_5555_1234_5670, ub = 64'h0F0F_F0F0_89AB_CDE0;
  logic [63:0] pv = 64'h3C3C_C3C3_0246_8AC0;
  logic [63:0] rdata, olb, oub, opv, maddr, mwdata, mrdata;
  logic busy, done, brf, udf, mreq, mwe, mwide, mack, got_f, got_u;
  int n_errors = 0, checks_done = 0, cyc = 0;
  always #2 clk = ~clk;
  btw_walker i_dut (.i_clk(clk), .i_sys_rst(rst), .i_init(init), .i_reg_addr(raddr),
    .i_reg_wdata(wdata), .i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rdata),
    .i_op_start(start), .i_op_store(store), .i_mode64(m64), .i_mode16(m16),
    .i_addr_prefix(pfx), .i_privilege_level(privilege_level), .i_seg_base(seg),
    .i_pointer_storage_addr(pa), .i_lower_bound(lb), .i_upper_bound(ub),
    .i_pointer_value(pv), .o_busy(busy), .o_done(done), .o_bound_range_fault(brf),
    .o_undefined_opcode_fault(udf), .o_lower_bound(olb), .o_upper_bound(oub),
    .o_pointer_value(opv), .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_wide(mwide),
    .o_mem_addr(maddr), .o_mem_wdata(mwdata), .i_mem_ack(mack), .i_mem_rdata(mrdata));
  btw_mem_model i_mem (.i_clk(clk), .i_sys_rst(rst), .i_mem_req(mreq), .i_mem_we(mwe),
    .i_mem_wide(mwide), .i_mem_addr(maddr), .i_mem_wdata(mwdata), .o_mem_ack(mack),
    .o_mem_rdata(mrdata));
  // ==========================================================
  // Expected addresses and access tasks.
  function automatic logic [63:0] de_addr(input logic w, input logic [1:0] pl,
                                          input logic [63:0] la);
    logic [63:0] cfg;
    int adj;
    cfg = (pl == 2'h3) ? UCFG : SCFG;
    adj = (pl == 2'h3) ? WADJ : 0;
    if (w) begin
      return {cfg[63:12], 12'h0} + (((la >> 20) & ((64'h1 << (28 + adj)) - 64'h1)) << 3);
    end
    return {32'h0, cfg[31:12], 12'h0} + {42'h0, la[31:12], 2'h0};
  endfunction : de_addr
  function automatic logic [63:0] te_addr(input logic w, input logic [63:0] de,
                                          input logic [63:0] la);
    if (w) begin
      return {de[63:3], 3'h0} + {42'h0, la[19:3], 5'h0};
    end
    return {32'h0, de[31:2], 2'h0} + {50'h0, la[11:2], 4'h0} + DSEG;
  endfunction : te_addr
  task automatic wr(input logic [3:0] a, input logic [63:0] d);
    @(posedge clk);
    rwr <= 1'b1;
    raddr <= a;
    wdata <= d;
    @(posedge clk);
    rwr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [63:0] d);
    @(posedge clk);
    rrd <= 1'b1;
    raddr <= a;
    @(posedge clk);
    rrd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic run(input logic st, w, h, p, input logic [1:0] pl, input logic [63:0] sg, ad);
    for (int i = 0; i < 50 && busy !== 1'b0; i++) begin
      @(posedge clk);
    end
    @(posedge clk);
    store <= st;
    m64 <= w;
    m16 <= h;
    pfx <= p;
    privilege_level <= pl;
    seg <= sg;
    pa <= ad;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    `BTW_CHK(busy, !done, "busy while operating")
    for (int i = 0; i < 200 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    `BTW_CHK(done, 1'b1, "operation did not finish")
    `BTW_CHK(busy, 1'b0, "busy after finish")
    got_f = brf;
    got_u = udf;
  endtask : run
  task automatic sl(input logic w, input logic [1:0] pl, input logic [63:0] sg, ad, dv);
    logic [63:0] la, te, st, msk;
    int n0;
    la = sg + ad;
    i_mem.mem[de_addr(w, pl, la)] = dv;
    te = te_addr(w, dv, la);
    st = w ? 64'h8 : 64'h4;
    msk = w ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
    n0 = i_mem.n_acc;
    run(1'b1, w, 1'b0, w, pl, sg, ad);
    `BTW_CHK(i_mem.n_acc - n0, 5, "store access count")
    `BTW_CHK(i_mem.mem[te], lb & msk, "lower bound field")
    `BTW_CHK(i_mem.mem[te + st], ub & msk, "upper bound field")
    `BTW_CHK(i_mem.mem[te + 2 * st], pv & msk, "pointer field")
    `BTW_CHK(i_mem.mem[te + 3 * st], 64'h0, "reserved field")
    i_mem.mem[te] = ub & msk;
    i_mem.mem[te + st] = pv & msk;
    i_mem.mem[te + 2 * st] = lb & msk;
    n0 = i_mem.n_acc;
    run(1'b0, w, !w, !w, pl, sg, ad);
    `BTW_CHK(i_mem.n_acc - n0, 4, "load access count")
    `BTW_CHK({olb, oub, opv}, {ub & msk, pv & msk, lb & msk}, "load results")
    `BTW_CHK({got_f, got_u}, 2'h0, "unexpected fault")
  endtask : sl
  task automatic flt(input logic w, input logic [1:0] pl, input logic [63:0] ad, dv);
    logic [63:0] de, msk;
    int n0;
    de = de_addr(w, pl, ad);
    i_mem.mem[de] = dv;
    msk = w ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
    n0 = i_mem.n_acc;
    run(w, w, 1'b0, 1'b0, pl, 64'h0, ad);
    `BTW_CHK(got_f, 1'b1, "missing fault")
    `BTW_CHK(i_mem.n_acc - n0, 1, "table access after bad entry")
    rd(4'h2, rv);
    `BTW_CHK(rv & msk, {de[63:2], 2'h2} & msk, "fault status")
  endtask : flt
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, "run timed out");
      end_of_test;
    end
  end
  // ==========================================================
  // Test sequence.
  initial begin
    int n0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 3; a++) begin
      rd(a[3:0], rv);
      `BTW_CHK(rv, 64'h0, "register reset value")
    end
    rd(4'hF, rv);
    `BTW_CHK(rv, 64'h0, "unmapped read")
    wr(4'h0, UCFG);
    wr(4'h1, SCFG);
    wr(4'h3, 64'(WADJ) << 17);
    wr(4'h4, DSEG);
    rd(4'h0, rv);
    `BTW_CHK(rv, UCFG, "user config readback")
    sl(1'b1, 2'h3, 64'h0080_0100_0000_0000, 64'h0000_0034_5678_9AB8,
       64'h0000_0005_0000_0007);
    sl(1'b1, 2'h0, 64'h0000_0000_0000_1000, 64'h0000_7FFF_FFF0_0010,
       64'h0000_0009_0000_0001);
    sl(1'b0, 2'h3, 64'h0000_0000_0100_0000, 64'h0000_0000_0234_5678,
       64'h0000_0000_0040_0003);
    flt(1'b1, 2'h0, 64'h0000_0012_3456_7000, 64'h0000_0000_0000_0006);
    flt(1'b0, 2'h3, 64'h0000_0000_8765_4000, 64'h0000_0000_0000_0002);
    n0 = i_mem.n_acc;
    for (int k = 0; k < 2; k++) begin
      run(1'b0, 1'b0, k[0], ~k[0], 2'h3, 64'h0, 64'h0000_0000_0000_1000);
      `BTW_CHK(got_u, 1'b1, "prefix fault")
    end
    `BTW_CHK(i_mem.n_acc - n0, 0, "access after prefix fault")
    @(posedge clk);
    init <= 1'b1;
    @(posedge clk);
    init <= 1'b0;
    rd(4'h0, rv);
    `BTW_CHK(rv, 64'h0, "user config after init")
    rd(4'h1, rv);
    `BTW_CHK(rv, 64'h0, "config after init")
    rd(4'h2, rv);
    `BTW_CHK(rv, 64'h0, "status after init")
    end_of_test;
  end
endmodule : btw_walker_test
`default_nettype wire
